// ==== hw/tams_defs.svh ====
`ifndef TAMS_DEFS_SVH
`define TAMS_DEFS_SVH
// register byte offsets
`define TAMS_REG_CTRL 8'h00
`define TAMS_REG_DETAIL 8'h04
`define TAMS_REG_MODE 8'h08
`define TAMS_REG_SIZE 8'h0c
`define TAMS_REG_BORDER 8'h10
`define TAMS_REG_STATUS 8'h14
`define TAMS_NUM_REGS 5
// writable bits and reset values
`define TAMS_MASK_CTRL 32'h0000_0f37
`define TAMS_MASK_DETAIL 32'h0fff_0fff
`define TAMS_MASK_MODE 32'h0000_0777
`define TAMS_MASK_SIZE 32'h0000_0fff
`define TAMS_MASK_BORDER 32'hffff_ffff
`define TAMS_RST_CTRL 32'h0000_0801
`define TAMS_RST_DETAIL 32'h0e00_0000
// ctrl and detail fields
`define TAMS_CTRL_SHIFT 0
`define TAMS_CTRL_FILT 2:1
`define TAMS_CTRL_BLEND 5:4
`define TAMS_CTRL_ASPECT 11:8
`define TAMS_DET_FLOOR 11:8
`define TAMS_DET_CEIL 27:24
// filter codes
`define TAMS_FILT_NEAREST 2'h0
`define TAMS_FILT_LINEAR 2'h1
`define TAMS_FILT_DIR 2'h2
// level blend codes
`define TAMS_BLEND_OFF 2'h0
`define TAMS_BLEND_ROUND 2'h1
`define TAMS_BLEND_LERP 2'h2
// axis address mode codes
`define TAMS_ADDR_EDGE 3'h0
`define TAMS_ADDR_REPEAT 3'h1
`define TAMS_ADDR_REFLECT 3'h2
`define TAMS_ADDR_CUBE 3'h3
`define TAMS_ADDR_BORDER 3'h4
`define TAMS_ADDR_SINGLE 3'h5
`define TAMS_ADDR_HALF 3'h6
`define TAMS_ADDR_SKIP 3'h7
// fixed-point constants, ways limit and bus response codes
`define TAMS_HALF_TEXEL 48'h0000_0000_8000
`define TAMS_ROUND_HALF 13'h0080
`define TAMS_FRAC_BITS 8
`define TAMS_MAX_WAYS_HALF 4'h8
`define TAMS_RESP_OKAY 2'h0
`define TAMS_RESP_SLVERR 2'h2
`endif

// ==== hw/tams_pkg.sv ====
package tams_pkg;
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } tams_axi_req_type;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tams_axi_rsp_type;
    typedef struct packed {
        logic signed [2:0][31:0] coord;
        logic [31:0] hom_recip;
        logic [11:0] lod;
        logic [19:0] major_len;
        logic [19:0] minor_len;
        logic signed [9:0] major_dir_x;
        logic signed [9:0] major_dir_y;
        logic [15:0] tag;
    } tams_req_type;
    typedef struct packed {
        logic [13:0] idx;
        logic border;
        logic half;
        logic [1:0] face;
    } tams_texel_type;
    typedef struct packed {
        tams_texel_type t0;
        tams_texel_type t1;
        logic [7:0] frac;
    } tams_axis_type;
    typedef struct packed {
        tams_axis_type [2:0] axis;
        logic [3:0] level0;
        logic [3:0] level1;
        logic [7:0] level_blend;
        logic two_levels;
        logic [4:0] ways;
        logic [3:0] end_weight;
        logic signed [9:0] step_x;
        logic signed [9:0] step_y;
        logic signed [13:0] start_x;
        logic signed [13:0] start_y;
        logic [31:0] border_ptr;
        logic [15:0] tag;
    } tams_fetch_type;
    typedef struct packed {
        logic [4:0][31:0] regs;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic out_valid;
        tams_fetch_type fetch;
        logic [15:0] accepted;
        logic border_seen;
    } tams_state_type;
endpackage

// ==== hw/tams_top.sv ====
// Function
// - centre shift with linear filter treats map as one texel smaller
// - aspect ratio capped by filter_aspect_limit, at most 16:1
// - minor axis length picks directional detail level
// - subpixel count is next even integer above axis ratio
// - subpixels lie on major axis one texel apart
// - bilinear subpixels; equal interior weight, ends by ratio
// - blend off uses finest level after clamping
// - round mode rounds detail to nearest level when minifying
// - lerp blends by detail fraction, truncated and next level
// - selected levels clamp to detail_floor..detail_ceiling
// - each axis resolves out-of-range values by its own mode
// - homogeneous component only scales the other three
// - edge clamp returns the edge texel
// - border clamp returns border colour via sampler pointer
// - half border returns edge and border colour midpoint
// - repeat wraps to the opposite side
// - cube seam fetches from the adjacent face
// - reflect mirrors at every integer boundary
// - reflect skip reflects once each way, skipping first texel; code mirrors only below zero and clamps above the map
// - exact up to 32 wraps; beyond, precision may degrade
// - reflect single mirrors absolute coordinate then clamps to one
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "tams_defs.svh"
module tams_top (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire tams_pkg::tams_axi_req_type axi_req_i,
    output tams_pkg::tams_axi_rsp_type axi_rsp_o,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire tams_pkg::tams_req_type req_i,
    output logic fetch_valid_o,
    input wire logic fetch_ready_i,
    output tams_pkg::tams_fetch_type fetch_o
);
    import tams_pkg::*;

    tams_state_type st_q;
    tams_state_type st_d;

    // ====================
    // axis addressing
    function automatic tams_texel_type resolve(input logic signed [24:0] t,
                                               input logic [3:0] lg,
                                               input logic [2:0] mode);
        logic signed [24:0] n;
        logic signed [24:0] a;
        logic signed [24:0] m;
        logic lo;
        logic hi;
        tams_texel_type r;
        n = 25'sd1 <<< lg;
        lo = t < 25'sd0;
        hi = t >= n;
        a = t;
        m = t & ((n <<< 1) - 25'sd1);
        r = '0;
        unique case (mode)
            `TAMS_ADDR_REPEAT: begin
                a = t & (n - 25'sd1);
            end
            `TAMS_ADDR_REFLECT: begin
                a = (m >= n) ? ((n <<< 1) - 25'sd1 - m) : m;
            end
            `TAMS_ADDR_CUBE: begin
                a = t & (n - 25'sd1);
                r.face = {hi, lo};
            end
            `TAMS_ADDR_SINGLE: begin
                a = lo ? (-25'sd1 - t) : t;
            end
            `TAMS_ADDR_SKIP: begin
                a = lo ? -t : t;
            end
            default: begin
                a = t;
            end
        endcase
        if (a < 25'sd0) begin
            a = 25'sd0;
        end else if (a >= n) begin
            a = n - 25'sd1;
        end
        r.idx = a[13:0];
        r.border = (mode == `TAMS_ADDR_BORDER) && (lo || hi);
        r.half = (mode == `TAMS_ADDR_HALF) && (lo || hi);
        return r;
    endfunction

    function automatic logic [3:0] clamp_level(input logic [4:0] lv,
                                               input logic [3:0] fl,
                                               input logic [3:0] ce);
        logic [4:0] r;
        r = lv;
        if (r > {1'b0, ce}) begin
            r = {1'b0, ce};
        end
        if (r < {1'b0, fl}) begin
            r = {1'b0, fl};
        end
        return r[3:0];
    endfunction

    // ====================
    // configuration views
    logic [31:0] ctrl;
    logic [1:0] filt;
    logic linear_like;
    logic corner;
    assign ctrl = st_q.regs[0];
    assign filt = ctrl[`TAMS_CTRL_FILT];
    assign linear_like = (filt != `TAMS_FILT_NEAREST);
    assign corner = ctrl[`TAMS_CTRL_SHIFT] && linear_like;

    // ====================
    // per-axis scaling
    tams_axis_type [2:0] axis_res;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_axis
            logic signed [64:0] prod;
            logic signed [31:0] scaled;
            logic signed [47:0] pos;
            logic [3:0] lg;
            logic [2:0] mode;
            logic signed [24:0] t0;
            assign lg = st_q.regs[3][gi*4 +: 4];
            assign mode = st_q.regs[2][gi*4 +: 3];
            // packed element reads unsigned, so sign it
            assign prod = $signed(req_i.coord[gi]) *
                $signed({1'b0, req_i.hom_recip});
            assign scaled = prod[47:16];
            // corner mode: map one texel smaller
            assign pos = corner ?
                ((48'(scaled) <<< lg) - 48'(scaled)) :
                ((48'(scaled) <<< lg) - (linear_like ? `TAMS_HALF_TEXEL : 48'h0));
            // 24 integer bits hold 32 wraps
            assign t0 = {pos[39], pos[39:16]};
            assign axis_res[gi].t0 = resolve(t0, lg, mode);
            assign axis_res[gi].t1 = resolve(t0 + (linear_like ? 25'sd1 : 25'sd0), lg, mode);
            assign axis_res[gi].frac = linear_like ? pos[15:8] : 8'h00;
        end
    endgenerate

    // ====================
    // directional footprint
    logic [11:0] lod_dir;
    always_comb begin
        logic [4:0] msb;
        logic [19:0] norm;
        msb = 5'd0;
        norm = '0;
        for (int b = 0; b < 20; b++) begin
            if (req_i.minor_len[b]) begin
                msb = 5'(b);
            end
        end
        norm = req_i.minor_len << (5'd19 - msb);
        if (msb < 5'(`TAMS_FRAC_BITS)) begin
            lod_dir = 12'h000;
        end else begin
            lod_dir = {4'(msb - 5'(`TAMS_FRAC_BITS)), norm[18:11]};
        end
    end

    // subpixel count: smallest even n with n*minor > major
    logic [8:1] way_hit;
    logic [8:1] wt_hit;
    logic [3:0] half_ways;
    logic [3:0] aspect_half;
    logic [24:0] rem;
    generate
        for (gi = 1; gi <= 8; gi++) begin : g_way
            assign way_hit[gi] = (25'(req_i.minor_len) * 25'(2 * gi)) > 25'(req_i.major_len);
            assign wt_hit[gi] = (27'(rem) << 2) >= (27'(req_i.minor_len) * 27'(gi));
        end
    endgenerate
    assign aspect_half = (ctrl[`TAMS_CTRL_ASPECT] == 4'h0) ? 4'h1 :
        ((ctrl[`TAMS_CTRL_ASPECT] > `TAMS_MAX_WAYS_HALF) ? `TAMS_MAX_WAYS_HALF :
        ctrl[`TAMS_CTRL_ASPECT]);
    always_comb begin
        logic [3:0] h;
        h = `TAMS_MAX_WAYS_HALF;
        for (int k = 8; k >= 1; k--) begin
            if (way_hit[k]) begin
                h = 4'(k);
            end
        end
        half_ways = (h > aspect_half) ? aspect_half : h;
    end
    // end weight in eighths: (ratio - (n-2)) / 2, saturating
    assign rem = (25'(req_i.major_len) > 25'(req_i.minor_len) * 25'({half_ways - 4'h1, 1'b0})) ?
        (25'(req_i.major_len) - 25'(req_i.minor_len) * 25'({half_ways - 4'h1, 1'b0})) : 25'd0;
    logic [3:0] end_weight;
    always_comb begin
        end_weight = 4'h0;
        for (int k = 1; k <= 8; k++) begin
            end_weight = end_weight + {3'b000, wt_hit[k]};
        end
    end
    logic signed [15:0] span_x;
    logic signed [15:0] span_y;
    // first subpixel (n-1)/2 steps back
    assign span_x = $signed({11'h0, half_ways, 1'b0} - 16'sd1) * 16'(req_i.major_dir_x);
    assign span_y = $signed({11'h0, half_ways, 1'b0} - 16'sd1) * 16'(req_i.major_dir_y);

    // ====================
    // level selection
    logic [11:0] lod_sel;
    logic [3:0] lvl0;
    logic [3:0] lvl1;
    logic [7:0] beta;
    logic two;
    always_comb begin
        logic [3:0] fl;
        logic [3:0] cl;
        logic [12:0] rnd;
        logic minify;
        fl = st_q.regs[1][`TAMS_DET_FLOOR];
        cl = st_q.regs[1][`TAMS_DET_CEIL];
        lod_sel = (filt == `TAMS_FILT_DIR) ? lod_dir : req_i.lod;
        minify = lod_sel != 12'h000;
        rnd = {1'b0, lod_sel} + `TAMS_ROUND_HALF;
        lvl0 = clamp_level(5'h00, fl, cl);
        lvl1 = lvl0;
        beta = 8'h00;
        two = 1'b0;
        unique case (ctrl[`TAMS_CTRL_BLEND])
            `TAMS_BLEND_ROUND: begin
                if (minify) begin
                    lvl0 = clamp_level(rnd[12:8], fl, cl);
                    lvl1 = lvl0;
                end
            end
            `TAMS_BLEND_LERP: begin
                if (minify) begin
                    lvl0 = clamp_level({1'b0, lod_sel[11:8]}, fl, cl);
                    lvl1 = clamp_level({1'b0, lod_sel[11:8]} + 5'h01, fl, cl);
                    beta = lod_sel[7:0];
                    two = 1'b1;
                end
            end
            default: begin
                lvl0 = clamp_level(5'h00, fl, cl);
            end
        endcase
    end

    // ====================
    // bus slave and pipeline
    logic take_req;
    logic aw_take;
    logic w_take;
    logic ar_take;
    assign req_ready_o = clk_en_i && (!st_q.out_valid || fetch_ready_i);
    assign take_req = req_valid_i && req_ready_o;
    assign aw_take = clk_en_i && axi_req_i.awvalid && !st_q.aw_held;
    assign w_take = clk_en_i && axi_req_i.wvalid && !st_q.w_held;
    assign ar_take = clk_en_i && axi_req_i.arvalid && !st_q.rvalid;

    function automatic logic [31:0] reg_mask(input logic [2:0] i);
        unique case (i)
            3'd0: reg_mask = `TAMS_MASK_CTRL;
            3'd1: reg_mask = `TAMS_MASK_DETAIL;
            3'd2: reg_mask = `TAMS_MASK_MODE;
            3'd3: reg_mask = `TAMS_MASK_SIZE;
            default: reg_mask = `TAMS_MASK_BORDER;
        endcase
    endfunction

    always_comb begin
        logic [2:0] widx;
        logic [2:0] ridx;
        logic [31:0] merged;
        st_d = st_q;
        widx = st_q.awaddr[4:2];
        ridx = axi_req_i.araddr[4:2];
        merged = '0;
        if (aw_take) begin
            st_d.aw_held = 1'b1;
            st_d.awaddr = axi_req_i.awaddr;
        end
        if (w_take) begin
            st_d.w_held = 1'b1;
            st_d.wdata = axi_req_i.wdata;
            st_d.wstrb = axi_req_i.wstrb;
        end
        if (st_q.bvalid && axi_req_i.bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = `TAMS_RESP_SLVERR;
            if (st_q.awaddr[1:0] == 2'b00 && st_q.awaddr < `TAMS_REG_STATUS) begin
                for (int b = 0; b < 4; b++) begin
                    merged[b*8 +: 8] = st_q.wstrb[b] ? st_q.wdata[b*8 +: 8] :
                        st_q.regs[widx][b*8 +: 8];
                end
                st_d.regs[widx] = merged & reg_mask(widx);
                st_d.bresp = `TAMS_RESP_OKAY;
            end else if (st_q.awaddr == `TAMS_REG_STATUS) begin
                st_d.bresp = `TAMS_RESP_OKAY;
            end
        end
        if (st_q.rvalid && axi_req_i.rready) begin
            st_d.rvalid = 1'b0;
        end
        if (ar_take) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = `TAMS_RESP_OKAY;
            st_d.rdata = '0;
            if (axi_req_i.araddr[1:0] != 2'b00 || axi_req_i.araddr > `TAMS_REG_STATUS) begin
                st_d.rresp = `TAMS_RESP_SLVERR;
            end else if (axi_req_i.araddr == `TAMS_REG_STATUS) begin
                st_d.rdata = {st_q.accepted, 14'h0, st_q.border_seen, st_q.out_valid};
            end else begin
                st_d.rdata = st_q.regs[ridx];
            end
        end
        if (st_q.out_valid && fetch_ready_i) begin
            st_d.out_valid = 1'b0;
        end
        if (take_req) begin
            st_d.out_valid = 1'b1;
            st_d.accepted = st_q.accepted + 16'h0001;
            st_d.fetch.axis = axis_res;
            st_d.fetch.level0 = lvl0;
            st_d.fetch.level1 = lvl1;
            st_d.fetch.level_blend = beta;
            st_d.fetch.two_levels = two;
            st_d.fetch.tag = req_i.tag;
            st_d.fetch.border_ptr = st_q.regs[4];
            st_d.border_seen = st_q.border_seen || axis_res[0].t0.border ||
                axis_res[1].t0.border || axis_res[2].t0.border;
            if (filt == `TAMS_FILT_DIR) begin
                st_d.fetch.ways = {half_ways, 1'b0};
                st_d.fetch.end_weight = end_weight;
                st_d.fetch.step_x = req_i.major_dir_x;
                st_d.fetch.step_y = req_i.major_dir_y;
                st_d.fetch.start_x = 14'(-(span_x >>> 1));
                st_d.fetch.start_y = 14'(-(span_y >>> 1));
            end else begin
                st_d.fetch.ways = 5'h01;
                st_d.fetch.end_weight = 4'h8;
                st_d.fetch.step_x = '0;
                st_d.fetch.step_y = '0;
                st_d.fetch.start_x = '0;
                st_d.fetch.start_y = '0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= '0;
            st_q.regs[0] <= `TAMS_RST_CTRL;
            st_q.regs[1] <= `TAMS_RST_DETAIL;
        end else if (clk_en_i) begin
            st_q <= st_d;
        end
    end

    // ====================
    // outputs
    assign axi_rsp_o.awready = clk_en_i && !st_q.aw_held;
    assign axi_rsp_o.wready = clk_en_i && !st_q.w_held;
    assign axi_rsp_o.bvalid = st_q.bvalid;
    assign axi_rsp_o.bresp = st_q.bresp;
    assign axi_rsp_o.arready = clk_en_i && !st_q.rvalid;
    assign axi_rsp_o.rvalid = st_q.rvalid;
    assign axi_rsp_o.rdata = st_q.rdata;
    assign axi_rsp_o.rresp = st_q.rresp;
    assign fetch_valid_o = st_q.out_valid;
    assign fetch_o = st_q.fetch;
endmodule // tams_top

// ==== test/tams_checker.sv ====
`timescale 1ns/1ps
module tams_checker (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire tams_pkg::tams_axi_req_type axi_req_i,
    input wire tams_pkg::tams_axi_rsp_type axi_rsp_o,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire tams_pkg::tams_req_type req_i,
    input wire logic fetch_valid_o,
    input wire logic fetch_ready_i,
    input wire tams_pkg::tams_fetch_type fetch_o
);
    import tams_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // ====================
    // handshake steps
    sequence s_take;
        req_valid_i && req_ready_o;
    endsequence
    sequence s_stall;
        fetch_valid_o && !(fetch_ready_i && clk_en_i);
    endsequence
    sequence s_bad_read;
        axi_req_i.arvalid && axi_rsp_o.arready && axi_req_i.araddr > 8'h14;
    endsequence
    // ====================
    // checks
    a_fetch_answer: assert property (s_take |=> fetch_valid_o && fetch_o.tag == $past(req_i.tag))
        else $error("no fetch");
    a_fetch_hold: assert property (s_stall |=> fetch_valid_o && $stable(fetch_o))
        else $error("fetch unstable");
    a_ready_gate: assert property (!clk_en_i |-> !req_ready_o && !axi_rsp_o.arready)
        else $error("ready frozen");
    a_bad_read: assert property (s_bad_read |=> axi_rsp_o.rvalid && axi_rsp_o.rresp == 2'h2
        && axi_rsp_o.rdata == 32'h0)
        else $error("bad read");
    a_read_hold: assert property (axi_rsp_o.rvalid && !(axi_req_i.rready && clk_en_i)
        |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
        else $error("read data dropped");
    a_ways_cap: assert property (fetch_valid_o |-> fetch_o.ways <= 5'd16)
        else $error("ways high");
    a_ways_even: assert property (fetch_valid_o && fetch_o.ways > 5'd1 |-> !fetch_o.ways[0])
        else $error("odd ways");
    a_end_weight: assert property (fetch_valid_o |-> fetch_o.end_weight <= 4'h8)
        else $error("weight high");
    a_level_pair: assert property (fetch_valid_o && fetch_o.two_levels |->
        fetch_o.level1 == fetch_o.level0 || fetch_o.level1 == fetch_o.level0 + 4'h1)
        else $error("bad level pair");
endmodule // tams_checker
bind tams_top tams_checker u_checker (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .axi_req_i(axi_req_i),
    .axi_rsp_o(axi_rsp_o),
    .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o),
    .req_i(req_i),
    .fetch_valid_o(fetch_valid_o),
    .fetch_ready_i(fetch_ready_i),
    .fetch_o(fetch_o)
);

// ==== test/tams_shader_model.sv ====
`timescale 1ns/1ps
module tams_shader_model (
    input wire logic core_clk_i,
    input wire logic req_ready_i,
    output logic req_valid_o,
    output tams_pkg::tams_req_type req_o
);
    import tams_pkg::*;
    tams_req_type q[$];
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // ====================
    // back-to-back requests; idle bus toggles
    always @(posedge core_clk_i) begin
        if (req_valid_o && req_ready_i) begin
            void'(q.pop_front());
        end
        req_valid_o <= q.size() != 0;
        req_o <= q.size() != 0 ? q[0] : ~req_o;
    end
endmodule // tams_shader_model

// ==== test/texture_address_mip_select_test.sv ====
`timescale 1ns/1ps
`include "tams_defs.svh"
module texture_address_mip_select_test;
    import tams_pkg::*;
    logic clk = 0;
    logic nrst = 0;
    logic ce = 1;
    logic fr = 0;
    logic ce_rand = 0;
    logic rv, rr, fv;
    tams_axi_req_type axi = '{bready: 1'b1, rready: 1'b1, default: '0};
    tams_axi_rsp_type rsp;
    tams_req_type rq, r;
    tams_fetch_type fo, e, m, fe, fm;
    tams_fetch_type eq[$], mq[$];
    integer mismatches = 0, n_checks = 0, seed = 32'h5697, i, j, k, t, w;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [2:0] md [3];
    integer lg [3] = '{4, 3, 2};
    tams_top dut (.core_clk_i(clk), .nrst_i(nrst), .clk_en_i(ce), .axi_req_i(axi),
        .axi_rsp_o(rsp), .req_valid_i(rv), .req_ready_o(rr), .req_i(rq), .fetch_valid_o(fv),
        .fetch_ready_i(fr), .fetch_o(fo));
    tams_shader_model core (.core_clk_i(clk), .req_ready_i(rr), .req_valid_o(rv), .req_o(rq));
    // ====================
    // tasks
    task test_done;
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task check(input string what, input logic [31:0] x, input logic [31:0] got);
        n_checks++;
        if (got !== x) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, x, got);
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        logic aw, wd;
        aw = 1;
        wd = 1;
        axi.awvalid <= 1;
        axi.awaddr <= a;
        axi.wvalid <= 1;
        axi.wdata <= d;
        axi.wstrb <= 4'hf;
        while (aw || wd) begin
            @(posedge clk);
            if (rsp.awready) aw = 0;
            if (rsp.wready) wd = 0;
            axi.awvalid <= aw;
            axi.wvalid <= wd;
        end
        do @(posedge clk); while (!(rsp.bvalid && ce));
    endtask
    task axr(input logic [7:0] a);
        axi.arvalid <= 1;
        axi.araddr <= a;
        do @(posedge clk); while (!rsp.arready);
        axi.arvalid <= 0;
        do @(posedge clk); while (!(rsp.rvalid && ce));
        rd = rsp.rdata;
        rs = rsp.rresp;
    endtask
    function integer cl(input integer x);
        return x < 1 ? 1 : (x > 3 ? 3 : x);
    endfunction
    function integer tex(input logic signed [31:0] c, input logic [31:0] h, integer l);
        return integer'((64'(c) * $signed({32'h0, h})) >>> (32 - l));
    endfunction
    function integer wrap(input logic [2:0] mo, input integer x, input integer l);
        integer s;
        s = 1 << l;
        if (mo == `TAMS_ADDR_REPEAT) return x & (s - 1);
        if (mo == `TAMS_ADDR_REFLECT) begin
            x = x & (2 * s - 1);
            return x < s ? x : 2 * s - 1 - x;
        end
        if (mo == `TAMS_ADDR_SINGLE && x < 0) x = -1 - x;
        return x < 0 ? 0 : (x >= s ? s - 1 : x);
    endfunction
    task base;
        r = '0;
        r.hom_recip = 32'h1_0000;
        r.tag = 16'($random(seed));
        e = '0;
        m = '0;
        e.tag = r.tag;
        m.tag = '1;
    endtask
    task axis(input integer a);
        t = tex(r.coord[a], r.hom_recip, lg[a]);
        w = t < 0 || t >= (1 << lg[a]);
        if (md[a] == `TAMS_ADDR_BORDER) begin
            e.axis[a].t0.border = w[0];
            m.axis[a].t0.border = 1;
        end else if (md[a] == `TAMS_ADDR_HALF) begin
            e.axis[a].t0.half = w[0];
            m.axis[a].t0.half = 1;
        end else begin
            e.axis[a].t0.idx = 14'(wrap(md[a], t, lg[a]));
            m.axis[a].t0.idx = '1;
        end
    endtask
    task send;
        eq.push_back(e);
        mq.push_back(m);
        core.q.push_back(r);
    endtask
    task drain;
        while (eq.size() != 0) @(posedge clk);
    endtask
    // ====================
    // stimulus and result
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done;
    end
    always @(posedge clk) begin
        fr <= ($random(seed) & 3) != 0;
        ce <= !ce_rand || ($random(seed) & 7) != 0;
    end
    always @(posedge clk) begin
        if (nrst && ce && fv && fr) begin
            fe = eq.pop_front();
            fm = mq.pop_front();
            n_checks++;
            if ((fo & fm) !== fe) begin
                mismatches++;
                $display("Error fetch expected %h seen %h", fe, fo & fm);
            end
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1;
        ce_rand = 1;
        @(posedge clk);
        axr(`TAMS_REG_CTRL);
        check("ctrl", `TAMS_RST_CTRL, rd);
        axr(`TAMS_REG_DETAIL);
        check("detail", `TAMS_RST_DETAIL, rd);
        axr(8'h18);
        check("bad resp", 32'(`TAMS_RESP_SLVERR), 32'(rs));
        axw(`TAMS_REG_MODE, 32'hffff_ffff);
        axr(`TAMS_REG_MODE);
        check("mode", `TAMS_MASK_MODE, rd);
        axw(`TAMS_REG_SIZE, 32'h234);
        axw(`TAMS_REG_BORDER, 32'h5a5a_c3c3);
        axw(`TAMS_REG_CTRL, 32'h0);
        for (k = 0; k < 2; k++) begin
            md = '{`TAMS_ADDR_EDGE, `TAMS_ADDR_REPEAT, `TAMS_ADDR_REFLECT};
            if (k) md = '{`TAMS_ADDR_BORDER, `TAMS_ADDR_HALF, `TAMS_ADDR_SINGLE};
            axw(`TAMS_REG_MODE, {21'h0, md[2], 1'b0, md[1], 1'b0, md[0]});
            for (i = 0; i < 30; i++) begin
                base;
                for (j = 0; j < 3; j++) r.coord[j] = $random(seed) >>> 11;
                if (i == 0) r.coord = {3{32'h0001_0000}};
                if (i == 1) r.coord = {3{32'hffff_ffff}};
                if (i[0]) r.hom_recip = 32'h8000;
                for (j = 0; j < 3; j++) axis(j);
                e.border_ptr = 32'h5a5a_c3c3;
                m.border_ptr = '1;
                send;
            end
            drain;
        end
        axw(`TAMS_REG_MODE, 32'h0);
        for (k = 0; k < 2; k++) begin
            axw(`TAMS_REG_CTRL, 32'h3 - k);
            base;
            r.coord[0] = 32'h0000_c000;
            e.axis[0].t0.idx = 14'd11;
            e.axis[0].frac = k ? 8'h80 : 8'h40;
            m.axis[0].t0.idx = '1;
            m.axis[0].frac = '1;
            send;
            drain;
        end
        axw(`TAMS_REG_DETAIL, 32'h0300_0100);
        for (k = 0; k < 3; k++) begin
            axw(`TAMS_REG_CTRL, k << 4);
            for (i = 0; i < 12; i++) begin
                base;
                r.lod = i ? 12'($random(seed)) : 12'h0;
                t = r.lod;
                w = k == 1 ? (t + 128) >> 8 : t >> 8;
                if (k == 0 || t == 0) w = 0;
                e.level0 = 4'(cl(w));
                m.level0 = '1;
                if (k == 2 && t != 0) begin
                    e.level1 = 4'(cl(w + 1));
                    m.level1 = '1;
                end
                if (k == 2 && w >= 1 && w < 3) begin
                    e.level_blend = t[7:0];
                    m.level_blend = '1;
                end
                send;
            end
            drain;
        end
        axw(`TAMS_REG_DETAIL, `TAMS_RST_DETAIL);
        for (k = 0; k < 2; k++) begin
            axw(`TAMS_REG_CTRL, k ? 32'h804 : 32'h304);
            for (i = 0; i < 12; i++) begin
                base;
                r.minor_len = 20'h100 + 20'($random(seed) & 32'h1ff);
                r.major_len = r.minor_len + 20'($random(seed) & 32'h1fff);
                if (i == 0) r.major_len = r.minor_len * 4;
                w = r.major_len / r.minor_len / 2 * 2 + 2;
                if (w > (k ? 16 : 6)) w = k ? 16 : 6;
                e.ways = 5'(w);
                m.ways = '1;
                send;
            end
            drain;
        end
        test_done;
    end
endmodule // texture_address_mip_select_test
